/* core/kwdt_prescaler.sv */
// Prescaled watchdog counter clocked by pclk and advanced by slow oscillator edges.
`timescale 1ns/1ps
module kwdt_prescaler
  import kwdt_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  kwdt_if.pre       lnk
);

  kwdt_count_t count;
  kwdt_count_t next_count;
  kwdt_count_t limit;

  // Terminal count follows the select field live, so a change acts on this period.
  // A clear in the same cycle as the last tick wins, so the period restarts in full.
  assign limit        = kwdt_limit(lnk.sel);
  assign lnk.overflow = lnk.run && lnk.osc_tick && !lnk.clear && (count >= limit);
  assign next_count   = lnk.clear    ? '0 :
                        lnk.overflow ? '0 :
                        (lnk.run && lnk.osc_tick) ? count + 1'b1 : count;

  // Counter advances once per slow oscillator edge while running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    lnk.clear |=> count == '0) else $error("counter not cleared");

  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !lnk.run && !lnk.clear |=> count == $past(count)) else $error("counter moved while stopped");
endmodule

/* core/kwdt_top.sv */
// Keyed watchdog timer with APB registers, reset-cause flag and interrupt.
//
// Behaviour
// - The counter counts slow oscillator edges through a prescaler of 2^8 to 2^18.
// - Select values 000 to 111 give ratios 2^8, 2^10, 2^12, 2^14, 2^15, 2^16, 2^17, 2^18.
// - Key 10101B disables the watchdog and key 01010B enables it.
// - Any other key value causes a full reset 2 to 3 slow oscillator cycles later.
// - A reset from an illegal key sets the key reset flag, bit 0 of the reset flags.
// - The key reset flag survives the reset, starts at zero and only software clears it.
// - After power-on the control register holds key 01010B and select 011.
// - Overflow in normal running causes a full reset and sets the time-out flag.
// - Overflow in sleep or idle sets the time-out flag and resets only PC and SP.
// - The counter is cleared by an illegal-key reset, a clear instruction or a halt.
// - Bits 7 to 3 of the reset flag register always read as zero.
// - A halt clears the counter, which resumes only if the watchdog is enabled.
// - Overflow in sleep or idle wakes the device and leaves other flags as they were.
// - Halt sets the power-down flag; power-up or the clear instruction clears it.
`timescale 1ns/1ps
`include "kwdt_defines.svh"
module kwdt_top
  import kwdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_osc_clock,
  input  wire logic        clear_watchdog_instruction,
  input  wire logic        halt_instruction,
  input  wire logic        sleep_mode,
  output logic             device_reset,
  output logic             pc_sp_reset,
  output logic             wake_up,
  output logic             timeout_flag,
  output logic             power_down_flag,
  output logic             irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  kwdt_if lnk ();

  logic [7:0]            watchdog_control;
  logic [2:0]            reset_cause_flags;
  logic                  key_reset_flag;
  logic [`KWDT_EV_W-1:0] irq_status;
  logic [`KWDT_EV_W-1:0] irq_mask;
  logic                  osc_prev;
  logic [1:0]            key_wait;
  logic [1:0]            next_key_wait;
  logic [4:0]            enable_key_field;
  logic [2:0]            timeout_select_field;
  logic                  key_enabled;
  logic                  key_disabled;
  logic                  key_bad;
  logic                  key_fire;
  logic                  ovf_normal;
  logic                  ovf_sleep;
  logic                  full_reset;
  logic                  setup;
  logic                  access;
  logic                  wr_en;
  logic                  rd_en;
  logic                  hit_ctl;
  logic                  hit_rcf;
  logic                  hit_sts;
  logic                  hit_ist;
  logic                  hit_msk;
  logic                  hit_any;
  logic [31:0]           rd_mux;
  logic [`KWDT_EV_W-1:0] events;
  logic [`KWDT_EV_W-1:0] next_irq_status;
  logic [7:0]            next_control;
  logic                  next_key_flag;
  logic                  next_timeout;
  logic                  next_pdown;

  // ****************************************************************
  // Key decode and oscillator edge
  // ****************************************************************
  // The control register fields and their legal key values.
  assign enable_key_field     = watchdog_control[`KWDT_KEY_MSB:`KWDT_KEY_LSB];
  assign timeout_select_field = watchdog_control[`KWDT_SEL_MSB:`KWDT_SEL_LSB];
  assign key_enabled  = enable_key_field == `KWDT_KEY_ENABLE;
  assign key_disabled = enable_key_field == `KWDT_KEY_DISABLE;
  assign key_bad      = !key_enabled && !key_disabled;

  // The slow oscillator is a synchronous input; a rising edge is one tick.
  assign lnk.osc_tick = slow_osc_clock && !osc_prev;

  // Three ticks after the key went bad lie 2 to 3 oscillator periods later.
  assign key_fire      = key_bad && lnk.osc_tick && (key_wait == `KWDT_KEY_TICKS - 2'h1);
  assign next_key_wait = !key_bad      ? 2'h0 :
                         lnk.osc_tick  ? key_wait + 2'h1 : key_wait;

  // ****************************************************************
  // Counter control
  // ****************************************************************
  // A disabled watchdog keeps its counter stopped, also after a halt.
  assign lnk.run   = key_enabled;
  assign lnk.sel   = timeout_select_field;
  assign lnk.clear = key_fire || clear_watchdog_instruction || halt_instruction;

  kwdt_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk)
  );

  // Overflow splits by power mode into full reset or a PC and SP reset.
  assign ovf_normal = lnk.overflow && !sleep_mode && !key_fire;
  assign ovf_sleep  = lnk.overflow && sleep_mode && !key_fire;
  assign full_reset = key_fire || ovf_normal;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Requests are taken in setup; the commit happens at the access edge.
  assign setup   = psel && !penable;
  assign access  = psel && penable && pready;
  assign wr_en   = access && pwrite;
  assign rd_en   = access && !pwrite;
  assign hit_ctl = paddr == `KWDT_OFS_CONTROL;
  assign hit_rcf = paddr == `KWDT_OFS_RESET_FLAG;
  assign hit_sts = paddr == `KWDT_OFS_STATUS;
  assign hit_ist = paddr == `KWDT_OFS_IRQ_STATUS;
  assign hit_msk = paddr == `KWDT_OFS_IRQ_MASK;
  assign hit_any = hit_ctl || hit_rcf || hit_sts || hit_ist || hit_msk;

  // Unused bits read as zero; reserved reset flag bits are never stored.
  assign reset_cause_flags = {2'h0, key_reset_flag};
  assign rd_mux = hit_ctl ? {24'h0, watchdog_control} :
                  hit_rcf ? {29'h0, reset_cause_flags[2:0]} :
                  hit_sts ? {30'h0, power_down_flag, timeout_flag} :
                  hit_ist ? {29'h0, irq_status} :
                  hit_msk ? {29'h0, irq_mask} : 32'h0;

  // ****************************************************************
  // Next state of registers and flags
  // ****************************************************************
  // A full reset this block raises reloads control; it wins over a software write.
  assign next_control = full_reset ? `KWDT_CONTROL_POR :
                        (wr_en && hit_ctl) ? pwdata[7:0] : watchdog_control;

  // The key flag is set by hardware and cleared only by a software zero; set wins.
  assign next_key_flag = key_fire ? 1'b1 :
                         (wr_en && hit_rcf && !pwdata[`KWDT_KEY_FLAG_BIT]) ? 1'b0 :
                         key_reset_flag;

  // Time-out is set by overflow and cleared by halt or the clear instruction.
  assign next_timeout = (ovf_normal || ovf_sleep) ? 1'b1 :
                        (halt_instruction || clear_watchdog_instruction) ? 1'b0 : timeout_flag;

  // Power-down is set by halt and cleared by the clear instruction.
  assign next_pdown = halt_instruction ? 1'b1 :
                      clear_watchdog_instruction ? 1'b0 : power_down_flag;

  // Sticky interrupt events; a read clears only the bits it returned, so an event
  // that lands between setup and access is kept, and a new event wins.
  assign events = '0 | ({`KWDT_EV_W{ovf_normal}} & 3'h1)
                     | ({`KWDT_EV_W{ovf_sleep}}  & 3'h2)
                     | ({`KWDT_EV_W{key_fire}}   & 3'h4);
  assign next_irq_status = events | ((rd_en && hit_ist) ?
                                     (irq_status & ~prdata[`KWDT_EV_W-1:0]) : irq_status);

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Watchdog state and flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev         <= 1'b0;
      key_wait         <= 2'h0;
      watchdog_control <= `KWDT_CONTROL_POR;
      key_reset_flag   <= 1'b0;
      timeout_flag     <= 1'b0;
      power_down_flag  <= 1'b0;
    end else begin
      osc_prev         <= slow_osc_clock;
      key_wait         <= next_key_wait;
      watchdog_control <= next_control;
      key_reset_flag   <= next_key_flag;
      timeout_flag     <= next_timeout;
      power_down_flag  <= next_pdown;
    end
  end

  // Reset requests and wake-up are one-cycle pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b0;
      pc_sp_reset  <= 1'b0;
      wake_up      <= 1'b0;
    end else begin
      device_reset <= full_reset;
      pc_sp_reset  <= ovf_sleep;
      wake_up      <= ovf_sleep;
    end
  end

  // Interrupt status, mask and the level interrupt output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= (wr_en && hit_msk) ? pwdata[`KWDT_EV_W-1:0] : irq_mask;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // Bus answer is prepared in setup and shown for the single access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= setup ? (pwrite ? 32'h0 : rd_mux) : prdata;
      pready  <= setup;
      pslverr <= setup && !hit_any;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_key_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    key_fire |=> key_reset_flag && device_reset) else $error("key reset not flagged");

  a_key_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    key_reset_flag && !(wr_en && hit_rcf) |=> key_reset_flag) else $error("key flag lost");

  a_bad_key_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(key_bad) |-> !key_fire ##1 (!key_fire || !$stable(key_wait)))
    else $error("illegal key fired too early");

  a_good_key_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !key_bad |-> !key_fire) else $error("legal key caused a reset");

  a_ovf_normal: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_normal |=> device_reset && timeout_flag && watchdog_control == `KWDT_CONTROL_POR)
    else $error("normal overflow mishandled");

  a_ovf_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_sleep |=> pc_sp_reset && wake_up && timeout_flag && !device_reset)
    else $error("sleep overflow mishandled");

  a_sleep_flags_keep: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_sleep && !halt_instruction && !clear_watchdog_instruction
      |=> power_down_flag == $past(power_down_flag)) else $error("sleep wake changed flags");

  a_halt_pdown: assert property (@(posedge pclk) disable iff (!presetn)
    halt_instruction |=> power_down_flag && !timeout_flag) else $error("halt flags wrong");

  a_clr_pdown: assert property (@(posedge pclk) disable iff (!presetn)
    clear_watchdog_instruction && !halt_instruction |=> !power_down_flag)
    else $error("clear did not drop power-down");

  a_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_rcf |=> prdata[7:3] == 5'h0) else $error("reserved bits nonzero");

  a_stop_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    key_disabled |-> !lnk.overflow) else $error("disabled watchdog overflowed");
endmodule

/* dv/kwdt_tb_top.sv */
// Self-checking testbench of the keyed watchdog timer.
`timescale 1ns/1ps
`include "kwdt_defines.svh"
module kwdt_tb_top
  import kwdt_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc;
  logic        clr_i;
  logic        halt_i;
  logic        sleep;
  logic        dev_rst;
  logic        pcsp;
  logic        wake;
  logic        to_f;
  logic        pd_f;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          compares;
  int          n_rst;
  int          n_pcsp;
  int          n_wake;

  kwdt_top dut (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .paddr                      (paddr),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .slow_osc_clock             (osc),
    .clear_watchdog_instruction (clr_i),
    .halt_instruction           (halt_i),
    .sleep_mode                 (sleep),
    .device_reset               (dev_rst),
    .pc_sp_reset                (pcsp),
    .wake_up                    (wake),
    .timeout_flag               (to_f),
    .power_down_flag            (pd_f),
    .irq                        (irq)
  );

  // ****************************************************************
  // Clock, pulse counters and hang guard
  // ****************************************************************
  // The clock toggles every 50 ns, half of its 100 ns period.
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // Reset pulses are counted at the falling edge, where they are settled.
  always @(negedge pclk) begin
    if (dev_rst === 1'b1) n_rst++;
    if (pcsp === 1'b1) n_pcsp++;
    if (wake === 1'b1) n_wake++;
  end

  // A run that hangs is cut short and reported as a failure.
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end

  // ****************************************************************
  // Tasks and functions
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compares a register or pin value.
  task automatic check(input string m, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Compares a count of reset pulses.
  task automatic chk_cnt(input string m, input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s count %0d expected %0d", $time, m, got, exp);
    end
  endtask

  // One APB transfer; pready is sampled at rising edges, and read data and error are
  // taken at the edge where it is seen high, before the request is released.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    i = 1;
    while (pready !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(a, 1'b0, 32'h0);
    check(m, rd, e);
  endtask

  // A one-cycle clear (h low) or halt (h high) instruction pulse; it returns at the
  // falling edge, once the flags it moves have settled.
  task automatic pulse(input bit h);
    @(posedge pclk);
    if (h) halt_i <= 1'b1;
    else clr_i <= 1'b1;
    @(posedge pclk);
    halt_i <= 1'b0;
    clr_i  <= 1'b0;
    @(negedge pclk);
  endtask

  // Slow oscillator ticks, one rising edge every two clock cycles, then settling time.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk) osc <= 1'b1;
      @(posedge pclk) osc <= 1'b0;
    end
    repeat (5) @(posedge pclk);
  endtask

  // Ticks per time-out for each select value.
  function automatic int ratio(input logic [2:0] s);
    case (s)
      3'h0: return 256;
      3'h1: return 1024;
      3'h2: return 4096;
      3'h3: return 16384;
      3'h4: return 32768;
      3'h5: return 65536;
      3'h6: return 131072;
      default: return 262144;
    endcase
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Reset, then each behaviour of the watchdog in turn.
  initial begin
    int         i;
    int         base;
    logic [2:0] sel;
    logic [4:0] key;
    {presetn, psel, penable, pwrite, osc, clr_i, halt_i, sleep} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    compares = 0;
    n_rst = 0;
    n_pcsp = 0;
    n_wake = 0;
    void'($urandom(84));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`KWDT_OFS_CONTROL, 32'h53, "control after reset");
    rd_chk(`KWDT_OFS_RESET_FLAG, 32'h0, "flags after reset");
    apb(8'h14, 1'b0, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    apb(`KWDT_OFS_IRQ_MASK, 1'b1, 32'h1);
    // Normal overflow for the first select value and two random ones.
    for (i = 0; i < 3; i++) begin
      sel = (i == 0) ? 3'h0 : 3'($urandom % 3);
      apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_ENABLE, sel});
      pulse(1'b0);
      apb(`KWDT_OFS_IRQ_STATUS, 1'b0, 32'h0);
      base = n_rst;
      tick(ratio(sel) - 1);
      chk_cnt("early overflow", n_rst, base);
      tick(1);
      chk_cnt("overflow reset", n_rst, base + 1);
      check("timeout flag", {31'h0, to_f}, 32'h1);
      check("irq raised", {31'h0, irq}, 32'h1);
      rd_chk(`KWDT_OFS_IRQ_STATUS, 32'h1, "irq status");
      @(negedge pclk);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    // Disabled key stops the count.
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_DISABLE, 3'h0});
    pulse(1'b0);
    base = n_rst;
    tick(300);
    chk_cnt("disabled", n_rst, base);
    // Halt clears the count and sets power down; clear instruction drops it.
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_ENABLE, 3'h0});
    pulse(1'b0);
    tick(200);
    pulse(1'b1);
    check("power down set", {31'h0, pd_f}, 32'h1);
    tick(200);
    chk_cnt("halt clears", n_rst, base);
    tick(56);
    chk_cnt("full period", n_rst, base + 1);
    pulse(1'b0);
    check("power down cleared", {31'h0, pd_f}, 32'h0);
    // Overflow in sleep resets only program counter and stack pointer.
    apb(`KWDT_OFS_IRQ_STATUS, 1'b0, 32'h0);
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_ENABLE, 3'h0});
    sleep <= 1'b1;
    pulse(1'b1);
    base = n_rst;
    tick(256);
    chk_cnt("pc sp reset", n_pcsp, 1);
    chk_cnt("wake up", n_wake, 1);
    chk_cnt("no full reset", n_rst, base);
    check("sleep timeout", {31'h0, to_f}, 32'h1);
    check("power down kept", {31'h0, pd_f}, 32'h1);
    rd_chk(`KWDT_OFS_STATUS, 32'h3, "status flags");
    check("masked irq", {31'h0, irq}, 32'h0);
    rd_chk(`KWDT_OFS_IRQ_STATUS, 32'h2, "sleep irq status");
    sleep <= 1'b0;
    // New select value applies to the running period.
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_ENABLE, 3'h2});
    pulse(1'b0);
    base = n_rst;
    tick(300);
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, `KWDT_KEY_ENABLE, 3'h0});
    tick(1);
    chk_cnt("live select", n_rst, base + 1);
    // Illegal key drawn at random.
    key = `KWDT_KEY_ENABLE;
    while (key == `KWDT_KEY_ENABLE || key == `KWDT_KEY_DISABLE) key = 5'($urandom % 32);
    apb(`KWDT_OFS_CONTROL, 1'b1, {24'h0, key, 3'h0});
    base = n_rst;
    tick(1);
    chk_cnt("key wait", n_rst, base);
    tick(2);
    chk_cnt("key reset", n_rst, base + 1);
    rd_chk(`KWDT_OFS_RESET_FLAG, 32'h1, "key flag set");
    rd_chk(`KWDT_OFS_CONTROL, 32'h53, "control reloaded");
    apb(`KWDT_OFS_RESET_FLAG, 1'b1, 32'hff);
    rd_chk(`KWDT_OFS_RESET_FLAG, 32'h1, "flag kept");
    apb(`KWDT_OFS_RESET_FLAG, 1'b1, 32'h0);
    rd_chk(`KWDT_OFS_RESET_FLAG, 32'h0, "flag cleared");
    report_and_stop;
  end
endmodule

/* inc/kwdt_defines.svh */
// Offsets, field positions, reset values and counts of the keyed watchdog.
`ifndef KWDT_DEFINES_SVH
`define KWDT_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define KWDT_OFS_CONTROL    8'h00
`define KWDT_OFS_RESET_FLAG 8'h04
`define KWDT_OFS_STATUS     8'h08
`define KWDT_OFS_IRQ_STATUS 8'h0c
`define KWDT_OFS_IRQ_MASK   8'h10

// ****************************************************************
// Fields and values
// ****************************************************************
`define KWDT_KEY_MSB        7
`define KWDT_KEY_LSB        3
`define KWDT_SEL_MSB        2
`define KWDT_SEL_LSB        0
`define KWDT_KEY_DISABLE    5'h15
`define KWDT_KEY_ENABLE     5'h0a
`define KWDT_CONTROL_POR    8'h53
`define KWDT_KEY_FLAG_BIT   0
`define KWDT_TIMEOUT_BIT    0
`define KWDT_PDOWN_BIT      1
`define KWDT_EV_OVF_NORMAL  0
`define KWDT_EV_OVF_SLEEP   1
`define KWDT_EV_KEY_RESET   2
`define KWDT_EV_W           3

// ****************************************************************
// Timing counts
// ****************************************************************
// Slow oscillator rising edges counted before an illegal key fires.
`define KWDT_KEY_TICKS      2'h3
`define KWDT_CNT_W          18

`endif

/* inc/kwdt_if.sv */
// Link between the watchdog control logic and its prescaler counter.
`timescale 1ns/1ps
interface kwdt_if;
  logic       osc_tick;
  logic       clear;
  logic       run;
  logic [2:0] sel;
  logic       overflow;

  modport ctl (output osc_tick, output clear, output run, output sel, input overflow);
  modport pre (input osc_tick, input clear, input run, input sel, output overflow);
endinterface

/* inc/kwdt_pkg.sv */
// Types and shared functions of the keyed watchdog.
package kwdt_pkg;
  `include "kwdt_defines.svh"

  typedef logic [`KWDT_CNT_W-1:0] kwdt_count_t;

  // Terminal count for a time-out select value: two to the chosen power, less one.
  function automatic kwdt_count_t kwdt_limit(input logic [2:0] sel);
    kwdt_count_t lim;
    lim = '0;
    unique case (sel)
      3'h0: lim = kwdt_count_t'(18'h000ff);
      3'h1: lim = kwdt_count_t'(18'h003ff);
      3'h2: lim = kwdt_count_t'(18'h00fff);
      3'h3: lim = kwdt_count_t'(18'h03fff);
      3'h4: lim = kwdt_count_t'(18'h07fff);
      3'h5: lim = kwdt_count_t'(18'h0ffff);
      3'h6: lim = kwdt_count_t'(18'h1ffff);
      3'h7: lim = kwdt_count_t'(18'h3ffff);
    endcase
    return lim;
  endfunction
endpackage
